// *** alarm_sup_pkg.sv ***
// Constants, field positions and state type of the alarm supervisor.
package alarm_sup_pkg;
	localparam int NUM_INPUTS   = 4;
	localparam int NUM_RESTART  = 96;
	localparam int SYNC_WIDTH   = 5 + NUM_INPUTS + NUM_RESTART;
	localparam logic [7:0] MAX_UNIT = 8'h5F;
	localparam logic [3:0] MAX_USED = 4'h4;
	localparam logic [3:0] MAX_AVG  = 4'h9;
	localparam logic [7:0] MODE_CYCLIC = 8'h00;
	localparam logic [7:0] MODE_DIRECT = 8'hA5;
	localparam logic [15:0] DATA_ZERO       = 16'h0000;
	localparam logic [15:0] DATA_DISCONNECT = 16'h7FFF;
	localparam logic [15:0] SCALE_LIMIT     = 16'h7FFF;
	localparam logic [15:0] ALARM_RESET     = 16'h0000;
	// Status area placement in the host I/O area.
	localparam logic [15:0] STATUS_BASE   = 16'h07D0;
	localparam logic [15:0] STATUS_STRIDE = 16'h000A;
	localparam logic [15:0] ALARM_REL     = 16'h0009;
	// Bit positions inside the alarm status word.
	localparam int BIT_DISC    = 0;
	localparam int BIT_SCALING = 8;
	localparam int BIT_RANGE   = 9;
	localparam int BIT_AVG     = 11;
	localparam int BIT_MODE    = 12;
	localparam int BIT_ADC     = 14;
	// Timing.
	localparam int CLK_PERIOD_NS      = 4;
	localparam int HOST_TIMEOUT_NS    = 1000000;
	localparam int HOST_TIMEOUT_CYCLES = HOST_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int RESTART_NS         = 1000;
	localparam int RESTART_CYCLES =
		(RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		ST_INIT    = 2'b00,
		ST_CHECK   = 2'b01,
		ST_RUN     = 2'b11,
		ST_RESTART = 2'b10
	} sup_state_t;
endpackage

// *** alarm_sup_sva.sv ***
// Port-level checker of the alarm supervisor, bound onto its top module.
`timescale 1ns/100ps
`default_nettype none
module alarm_sup_sva #(
	parameter int HOST_TIMEOUT_CYCLES = 20
) (
	// Clock, reset and watched inputs.
	input wire logic             clk_i,
	input wire logic             sys_rst_i,
	input wire logic [3:0]       used_count_i,
	input wire logic             host_refresh_i,
	input wire logic [3:0]       disconnect_i,
	input wire logic             adc_fault_i,
	// Watched outputs.
	input wire logic [15:0]      alarm_status_word_o,
	input wire logic [3:0][15:0] conv_data_o,
	input wire logic [15:0]      status_base_word_o,
	input wire logic [15:0]      alarm_word_addr_o,
	input wire logic             host_monitor_err_o,
	input wire logic             restarting_o,
	input wire logic             unit_error_indicator_o,
	input wire logic             run_indicator_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic prev_ref;
	int   quiet;
	// Cycles since the host last refreshed; the pin sync only adds slack.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prev_ref <= 1'b0;
			quiet    <= 0;
		end else begin
			prev_ref <= host_refresh_i;
			quiet    <= (host_refresh_i && !prev_ref) ? 0 : quiet + 1;
		end
	end
	// A setting flag shown on two cycles running, so indicators caught up.
	sequence s_flag2;
		(|alarm_status_word_o[12:8]) ##1 (|alarm_status_word_o[12:8]);
	endsequence
	sequence s_rs2;
		restarting_o ##1 restarting_o;
	endsequence
	property p_res;
		(alarm_status_word_o & 16'hA4F0) == 16'h0000;
	endproperty
	property p_addr;
		alarm_word_addr_o == status_base_word_o + 16'h0009;
	endproperty
	property p_uerr;
		unit_error_indicator_o == (|alarm_status_word_o[15:8]);
	endproperty
	property p_zero;
		(|alarm_status_word_o[12:8]) |-> ##1 (conv_data_o == 64'h0);
	endproperty
	property p_run;
		s_flag2 |-> !run_indicator_o;
	endproperty
	property p_disc;
		disconnect_i[0] && (used_count_i != 4'h0) |=> alarm_status_word_o[0];
	endproperty
	property p_adc;
		adc_fault_i |=> alarm_status_word_o[14];
	endproperty
	property p_adc_hold;
		adc_fault_i && !(|alarm_status_word_o[12:8]) |=> $stable(conv_data_o);
	endproperty
	property p_hold;
		s_rs2 |-> $stable(conv_data_o);
	endproperty
	property p_mon;
		$rose(host_monitor_err_o) |-> quiet >= HOST_TIMEOUT_CYCLES;
	endproperty
	a_res: assert property (p_res) else $error("reserved alarm bit set");
	a_addr: assert property (p_addr) else $error("alarm word address");
	a_uerr: assert property (p_uerr) else $error("unit error lamp");
	a_zero: assert property (p_zero) else $error("data not zero");
	a_run: assert property (p_run) else $error("run lamp lit");
	a_disc: assert property (p_disc) else $error("no disconnect bit");
	a_adc: assert property (p_adc) else $error("no converter bit");
	a_adc_hold: assert property (p_adc_hold) else $error("data moved");
	a_hold: assert property (p_hold) else $error("data moved in restart");
	a_mon: assert property (p_mon) else $error("early host timeout");
endmodule
bind analog_input_alarm_supervisor alarm_sup_sva #(
	.HOST_TIMEOUT_CYCLES(HOST_TIMEOUT_CYCLES)
) u_sva (
	.clk_i, .sys_rst_i, .used_count_i, .host_refresh_i, .disconnect_i,
	.adc_fault_i, .alarm_status_word_o, .conv_data_o, .status_base_word_o,
	.alarm_word_addr_o, .host_monitor_err_o, .restarting_o,
	.unit_error_indicator_o, .run_indicator_o
);
`default_nettype wire

// *** analog_input_alarm_supervisor.sv ***
// Alarm, indicator and host-link supervisor of a four-input analog unit.
//
// How it works
// - Bad initial setting other than unit number lights unit error, alarm flag.
// - Bad scaling sets bit 08, zero data.
// - Bit 09 on bad input count or range.
// - Bit 11 when averaging count exceeds nine.
// - Bit 12 unless mode is 00 or A5.
// - Setting flags clear only after reset or restart.
// - Bus or watchdog error lights host error, run.
// - Bus error forces conversion data to zero.
// - Host silence flags error, data held.
// - Watchdog error leaves data undefined.
// - Bad unit number: host error, run off, zero.
// - Unit table mismatch acts like duplicated number.
// - One host restart bit per unit number.
// - Previous data stays visible during restart.
// - Direct mode reports disconnection as 7FFF.
// - Only inputs within used count update.
// - Peak hold keeps the maximum value outside direct mode.
// - Status base word is 2000 plus ten units.
// - Bits 00 to 03 follow disconnection of used inputs.
// - Converter fault sets bit 14, holds data.
`timescale 1ns/100ps
`default_nettype none
module analog_input_alarm_supervisor #(
	parameter int HOST_TIMEOUT_CYCLES = alarm_sup_pkg::HOST_TIMEOUT_CYCLES
) (
	// Clock and reset.
	input  wire logic                    clk_i,
	input  wire logic                    sys_rst_i,
	// Initial settings from the setup memory, stable outside restarts.
	input  wire logic [7:0]              unit_number_i,
	input  wire logic [3:0]              used_count_i,
	input  wire logic [3:0][3:0]         range_code_i,
	input  wire logic [3:0][3:0]         avg_count_i,
	input  wire logic [7:0]              conv_mode_i,
	input  wire logic [3:0][15:0]        scale_lo_i,
	input  wire logic [3:0][15:0]        scale_hi_i,
	// Host link pins, asynchronous to clk_i.
	input  wire logic                    io_bus_err_i,
	input  wire logic                    host_watchdog_err_i,
	input  wire logic                    host_refresh_i,
	input  wire logic                    unit_dup_i,
	input  wire logic                    table_mismatch_i,
	input  wire logic                    direct_conversion_command_i,
	input  wire logic [3:0]              peak_hold_i,
	input  wire logic [95:0]             restart_bits_i,
	// Converter side, same clock domain.
	input  wire logic [3:0][15:0]        sample_i,
	input  wire logic                    sample_valid_i,
	input  wire logic [3:0]              disconnect_i,
	input  wire logic                    adc_fault_i,
	// Status toward the host.
	output logic [15:0]                  alarm_status_word_o,
	output logic [3:0][15:0]             conv_data_o,
	output logic [15:0]                  status_base_word_o,
	output logic [15:0]                  alarm_word_addr_o,
	output logic                         host_monitor_err_o,
	output logic                         restarting_o,
	// Front panel indicators.
	output logic                         unit_error_indicator_o,
	output logic                         host_error_indicator_o,
	output logic                         run_indicator_o
);
	setup_if st ();

	// Settings go through the checker over the interface.
	assign st.unit_number = unit_number_i;
	assign st.used_count  = used_count_i;
	assign st.range_code  = range_code_i;
	assign st.avg_count   = avg_count_i;
	assign st.conv_mode   = conv_mode_i;
	assign st.scale_lo    = scale_lo_i;
	assign st.scale_hi    = scale_hi_i;

	setting_check u_check (
		.st (st.checker_side)
	);

	// Two-flop synchronisers for every host pin.
	logic [alarm_sup_pkg::SYNC_WIDTH-1:0] sync1;
	logic [alarm_sup_pkg::SYNC_WIDTH-1:0] sync2;
	wire  [alarm_sup_pkg::SYNC_WIDTH-1:0] pins = {restart_bits_i,
		peak_hold_i, direct_conversion_command_i, table_mismatch_i,
		unit_dup_i, host_refresh_i, io_bus_err_i};
	logic wdt_s1;
	logic wdt_s2;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync1     <= '0;
			sync2     <= '0;
			wdt_s1    <= 1'b0;
			wdt_s2    <= 1'b0;
		end else begin
			sync1     <= pins;
			sync2     <= sync1;
			wdt_s1    <= host_watchdog_err_i;
			wdt_s2    <= wdt_s1;
		end
	end

	// Named views of the synchronised pins; pins are never combined
	// before their flops, so no glitch can reach the first stage.
	wire        bus_err_s   = sync2[0];
	wire        link_fault  = bus_err_s | wdt_s2;
	wire        refresh_s   = sync2[1];
	wire        dup_s       = sync2[2];
	wire        mismatch_s  = sync2[3];
	wire        direct_s    = sync2[4];
	wire [3:0]  peak_s      = sync2[8:5];
	wire [95:0] restart_s   = sync2[alarm_sup_pkg::SYNC_WIDTH-1:9];

	// Edge detectors read only the second synchroniser stage.
	logic refresh_d;
	logic direct_d;
	logic restart_d;
	wire  own_restart = (unit_number_i <= alarm_sup_pkg::MAX_UNIT) &&
		restart_s[unit_number_i[6:0]];
	wire  restart_rise = own_restart && !restart_d;
	wire  refresh_rise = refresh_s && !refresh_d;
	wire  direct_rise  = direct_s && !direct_d;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			refresh_d <= 1'b0;
			direct_d  <= 1'b0;
			restart_d <= 1'b0;
		end else begin
			refresh_d <= refresh_s;
			direct_d  <= direct_s;
			restart_d <= own_restart;
		end
	end

	// Supervisor state and restart hold timer.
	alarm_sup_pkg::sup_state_t state;
	alarm_sup_pkg::sup_state_t next_state;
	logic [15:0] hold_cnt;
	wire  hold_done = hold_cnt ==
		16'(alarm_sup_pkg::RESTART_CYCLES - 1);

	always_comb begin
		next_state = state;
		case (state)
			alarm_sup_pkg::ST_INIT: begin
				next_state = alarm_sup_pkg::ST_CHECK;
			end
			alarm_sup_pkg::ST_CHECK: begin
				next_state = alarm_sup_pkg::ST_RUN;
			end
			alarm_sup_pkg::ST_RUN: begin
				if (restart_rise) begin
					next_state = alarm_sup_pkg::ST_RESTART;
				end
			end
			alarm_sup_pkg::ST_RESTART: begin
				if (hold_done) begin
					next_state = alarm_sup_pkg::ST_CHECK;
				end
			end
			default: begin
				next_state = alarm_sup_pkg::ST_INIT;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state    <= alarm_sup_pkg::ST_INIT;
			hold_cnt <= 16'h0000;
		end else begin
			state    <= next_state;
			hold_cnt <= (state == alarm_sup_pkg::ST_RESTART) ?
				hold_cnt + 16'h0001 : 16'h0000;
		end
	end

	// Setting flags are taken only at a check; a fixed setting stays
	// flagged until reset or restart runs the check again.
	logic err_scaling;
	logic err_range;
	logic err_avg;
	logic err_mode;
	logic err_unit;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			err_scaling <= 1'b0;
			err_range   <= 1'b0;
			err_avg     <= 1'b0;
			err_mode    <= 1'b0;
			err_unit    <= 1'b0;
		end else if (state == alarm_sup_pkg::ST_CHECK) begin
			err_scaling <= st.err_scaling;
			err_range   <= st.err_range;
			err_avg     <= st.err_avg;
			err_mode    <= st.err_mode;
			err_unit    <= st.err_unit;
		end
	end

	// Host response monitor; only counts while the unit is running.
	logic [31:0] mon_cnt;
	logic        mon_err;
	wire  mon_expired = mon_cnt == 32'(HOST_TIMEOUT_CYCLES - 1);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mon_cnt <= 32'h0000_0000;
			mon_err <= 1'b0;
		end else if (refresh_rise ||
			state != alarm_sup_pkg::ST_RUN) begin
			mon_cnt <= 32'h0000_0000;
			mon_err <= 1'b0;
		end else if (mon_expired) begin
			mon_err <= 1'b1;
		end else begin
			mon_cnt <= mon_cnt + 32'h0000_0001;
		end
	end

	// Fault grouping that decides what the data words do.
	wire setting_err = err_scaling | err_range | err_avg | err_mode;
	wire unit_fault  = err_unit | dup_s | mismatch_s;
	wire force_zero  = setting_err | unit_fault | bus_err_s;
	wire freeze      = adc_fault_i | mon_err | wdt_s2 |
		(state != alarm_sup_pkg::ST_RUN);
	wire direct_mode = conv_mode_i == alarm_sup_pkg::MODE_DIRECT;

	// A direct request waits for the next converter sample; a new
	// command on the same cycle as consumption is kept.
	logic direct_pend;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			direct_pend <= 1'b0;
		end else if (direct_rise) begin
			direct_pend <= 1'b1;
		end else if (sample_valid_i && !freeze) begin
			direct_pend <= 1'b0;
		end
	end

	wire take = sample_valid_i && !freeze &&
		(!direct_mode || direct_pend);

	// Per-input next value.  The watchdog case simply freezes, which
	// is one legal reading of an undefined state.
	logic [3:0][15:0] next_data;

	for (genvar i = 0; i < 4; i++) begin : g_data
		wire used   = 4'(i) < used_count_i;
		wire peak   = peak_s[i] && !direct_mode;
		wire higher = $signed(sample_i[i]) > $signed(conv_data_o[i]);
		wire [15:0] fresh = disconnect_i[i] ?
			alarm_sup_pkg::DATA_DISCONNECT :
			((peak && !higher) ? conv_data_o[i] : sample_i[i]);
		assign next_data[i] = force_zero ? alarm_sup_pkg::DATA_ZERO :
			((take && used) ? fresh : conv_data_o[i]);
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			conv_data_o <= '0;
		end else begin
			conv_data_o <= next_data;
		end
	end

	// Alarm status word: setting flags held, live bits follow inputs.
	logic [15:0] next_alarm;
	logic [3:0]  used_mask;

	for (genvar i = 0; i < 4; i++) begin : g_mask
		assign used_mask[i] = 4'(i) < used_count_i;
	end

	always_comb begin
		next_alarm = alarm_sup_pkg::ALARM_RESET;
		next_alarm[alarm_sup_pkg::BIT_DISC +: 4] =
			disconnect_i & used_mask;
		next_alarm[alarm_sup_pkg::BIT_SCALING] = err_scaling;
		next_alarm[alarm_sup_pkg::BIT_RANGE]   = err_range;
		next_alarm[alarm_sup_pkg::BIT_AVG]     = err_avg;
		next_alarm[alarm_sup_pkg::BIT_MODE]    = err_mode;
		next_alarm[alarm_sup_pkg::BIT_ADC]     = adc_fault_i;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			alarm_status_word_o <= alarm_sup_pkg::ALARM_RESET;
		end else begin
			alarm_status_word_o <= next_alarm;
		end
	end

	// Indicators and host-side status from flip-flops.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			unit_error_indicator_o <= 1'b0;
			host_error_indicator_o <= 1'b0;
			run_indicator_o        <= 1'b0;
			host_monitor_err_o     <= 1'b0;
			restarting_o           <= 1'b0;
			status_base_word_o     <= alarm_sup_pkg::STATUS_BASE;
			alarm_word_addr_o      <= alarm_sup_pkg::STATUS_BASE +
				alarm_sup_pkg::ALARM_REL;
		end else begin
			unit_error_indicator_o <= |next_alarm[15:8];
			host_error_indicator_o <= link_fault | unit_fault |
				mon_err;
			run_indicator_o <= (state == alarm_sup_pkg::ST_RUN) &&
				!unit_fault && !setting_err;
			host_monitor_err_o <= mon_err;
			restarting_o <= state == alarm_sup_pkg::ST_RESTART;
			status_base_word_o <= alarm_sup_pkg::STATUS_BASE +
				16'(unit_number_i * alarm_sup_pkg::STATUS_STRIDE);
			alarm_word_addr_o <= alarm_sup_pkg::STATUS_BASE +
				16'(unit_number_i * alarm_sup_pkg::STATUS_STRIDE) +
				alarm_sup_pkg::ALARM_REL;
		end
	end
endmodule
`default_nettype wire

// *** host_model.sv ***
// Behavioural host controller: refresh strobe, restart bits and command.
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// Clock and requests from the bench.
	input  wire logic       clk_i,
	input  wire logic       refresh_en_i,
	input  wire logic       restart_req_i,
	input  wire logic [7:0] restart_unit_i,
	input  wire logic       cmd_req_i,
	// Host link toward the unit.
	output logic            host_refresh_o,
	output logic [95:0]     restart_bits_o,
	output logic            direct_conversion_command_o
);
	logic [2:0] phase = 3'h0;
	// Refresh rises every eight cycles, well inside the monitor timeout.
	always @(posedge clk_i) begin
		phase <= phase + 3'h1;
	end
	assign host_refresh_o = refresh_en_i & phase[2];
	// One restart bit per unit number; the bench fixes settings first.
	assign restart_bits_o =
		restart_req_i ? 96'h1 << restart_unit_i : 96'h0;
	// The command only appears when the program asks for it.
	assign direct_conversion_command_o = cmd_req_i;
endmodule
`default_nettype wire

// *** setting_check.sv ***
// Combinational validation of the initial settings.
`timescale 1ns/100ps
`default_nettype none
module setting_check (
	setup_if.checker_side st
);
	// Only codes 0, 2, 3, 6 and 7 select a supported signal range.
	function automatic logic range_ok(input logic [3:0] code);
		range_ok = (code == 4'h0) || (code == 4'h2) || (code == 4'h3) ||
			(code == 4'h6) || (code == 4'h7);
	endfunction

	// A scaling limit above the signed maximum is out of range.
	function automatic logic scale_bad(input logic [15:0] lo,
		input logic [15:0] hi);
		scale_bad = (lo > alarm_sup_pkg::SCALE_LIMIT) ||
			(hi > alarm_sup_pkg::SCALE_LIMIT) ||
			((lo == hi) && (lo != alarm_sup_pkg::DATA_ZERO));
	endfunction

	logic [3:0] bad_range;
	logic [3:0] bad_avg;
	logic [3:0] bad_scale;

	// Per-input checks; only scaling is limited to used inputs, range and averaging cover all four.
	for (genvar i = 0; i < 4; i++) begin : g_in
		assign bad_range[i] = !range_ok(st.range_code[i]);
		assign bad_avg[i]   = st.avg_count[i] > alarm_sup_pkg::MAX_AVG;
		assign bad_scale[i] = (4'(i) < st.used_count) &&
			scale_bad(st.scale_lo[i], st.scale_hi[i]);
	end

	// Verdicts handed back to the supervisor.
	assign st.err_scaling = |bad_scale;
	assign st.err_range   = (st.used_count > alarm_sup_pkg::MAX_USED) ||
		(|bad_range);
	assign st.err_avg     = |bad_avg;
	assign st.err_mode    = (st.conv_mode != alarm_sup_pkg::MODE_CYCLIC) &&
		(st.conv_mode != alarm_sup_pkg::MODE_DIRECT);
	assign st.err_unit    = st.unit_number > alarm_sup_pkg::MAX_UNIT;
endmodule
`default_nettype wire

// *** setup_if.sv ***
// Interface carrying initial settings to the checker and its verdicts back.
`timescale 1ns/100ps
`default_nettype none
interface setup_if;
	logic [7:0]       unit_number;
	logic [3:0]       used_count;
	logic [3:0][3:0]  range_code;
	logic [3:0][3:0]  avg_count;
	logic [7:0]       conv_mode;
	logic [3:0][15:0] scale_lo;
	logic [3:0][15:0] scale_hi;
	logic             err_scaling;
	logic             err_range;
	logic             err_avg;
	logic             err_mode;
	logic             err_unit;
	modport checker_side (
		input  unit_number, used_count, range_code, avg_count,
		input  conv_mode, scale_lo, scale_hi,
		output err_scaling, err_range, err_avg, err_mode, err_unit
	);
	modport owner_side (
		output unit_number, used_count, range_code, avg_count,
		output conv_mode, scale_lo, scale_hi,
		input  err_scaling, err_range, err_avg, err_mode, err_unit
	);
endinterface
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the analog input alarm supervisor.
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int TMO = 20;
	logic             clk_i, sys_rst_i, io_bus_err_i, host_watchdog_err_i;
	logic             unit_dup_i, table_mismatch_i, sample_valid_i;
	logic             adc_fault_i, refresh_en, restart_req, cmd_req;
	logic             host_refresh_i, direct_conversion_command_i;
	logic [7:0]       unit_number_i, conv_mode_i;
	logic [3:0]       used_count_i, peak_hold_i, disconnect_i;
	logic [3:0][3:0]  range_code_i, avg_count_i;
	logic [3:0][15:0] scale_lo_i, scale_hi_i, sample_i, conv_data_o;
	logic [95:0]      restart_bits_i;
	logic [15:0]      alarm_status_word_o, status_base_word_o;
	logic [15:0]      alarm_word_addr_o;
	logic             host_monitor_err_o, restarting_o;
	logic             unit_error_indicator_o, host_error_indicator_o;
	logic             run_indicator_o;
	int               fail_count, n_compared;
	logic [4:0]       err_bit [6] = '{5'h08, 5'h08, 5'h09, 5'h09, 5'h0B, 5'h0C};
	analog_input_alarm_supervisor #(.HOST_TIMEOUT_CYCLES(TMO)) DUT (
		.clk_i, .sys_rst_i, .unit_number_i, .used_count_i, .range_code_i,
		.avg_count_i, .conv_mode_i, .scale_lo_i, .scale_hi_i, .io_bus_err_i,
		.host_watchdog_err_i, .host_refresh_i, .unit_dup_i, .table_mismatch_i,
		.direct_conversion_command_i, .peak_hold_i, .restart_bits_i,
		.sample_i, .sample_valid_i, .disconnect_i, .adc_fault_i,
		.alarm_status_word_o, .conv_data_o, .status_base_word_o,
		.alarm_word_addr_o, .host_monitor_err_o, .restarting_o,
		.unit_error_indicator_o, .host_error_indicator_o, .run_indicator_o
	);
	host_model host (
		.clk_i, .refresh_en_i(refresh_en), .restart_req_i(restart_req),
		.restart_unit_i(unit_number_i), .cmd_req_i(cmd_req),
		.host_refresh_o(host_refresh_i), .restart_bits_o(restart_bits_i),
		.direct_conversion_command_o(direct_conversion_command_i)
	);
	// Free-running 250 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Legal settings for unit 17 with two inputs in use.
	task automatic good();
		unit_number_i = 8'h11;
		used_count_i = 4'h2;
		range_code_i = 16'h7630;
		avg_count_i = 16'h9090;
		conv_mode_i = 8'h00;
		scale_lo_i = 64'h0;
		scale_hi_i = 64'h0;
	endtask
	task automatic rst();
		sys_rst_i = 1'b1;
		step(4);
		chk(status_base_word_o, 16'h07D0);
		chk(alarm_word_addr_o, 16'h07D9);
		sys_rst_i = 1'b0;
		step(8);
	endtask
	task automatic smp(input logic [63:0] v);
		sample_i = v;
		sample_valid_i = 1'b1;
		step(1);
		sample_valid_i = 1'b0;
		step(2);
	endtask
	// Bounded wait for the restart flag; the watchdog catches a hang.
	task automatic waitrs(input logic lv);
		int k;
		k = 0;
		while (restarting_o !== lv && k < 400) begin
			step(1);
			k++;
		end
	endtask
	// Restart through the host bit while a new sample is offered.
	task automatic restart(input logic [63:0] held);
		restart_req = 1'b1;
		waitrs(1'b1);
		chk(restarting_o, 1'b1);
		smp(64'h0000_0000_0333_0333);
		chk(conv_data_o, held);
		restart_req = 1'b0;
		waitrs(1'b0);
		chk(restarting_o, 1'b0);
		step(6);
	endtask
	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#60000;
		fail_count++;
		conclude();
	end
	initial begin
		int i;
		fail_count = 0;
		n_compared = 0;
		sys_rst_i = 1'b1;
		{io_bus_err_i, host_watchdog_err_i, unit_dup_i} = 3'h0;
		{table_mismatch_i, sample_valid_i, adc_fault_i} = 3'h0;
		{restart_req, cmd_req, peak_hold_i, disconnect_i} = 10'h000;
		refresh_en = 1'b1;
		sample_i = 64'h0;
		good();
		rst();
		chk(status_base_word_o, 16'h087A);
		chk(alarm_word_addr_o, 16'h0883);
		chk(alarm_status_word_o, 16'h0000);
		chk(run_indicator_o, 1'b1);
		peak_hold_i = 4'h1;
		step(4);
		smp(64'h0000_0000_0050_0100);
		chk(conv_data_o, 64'h0000_0000_0050_0100);
		smp(64'h1234_1234_0040_0030);
		chk(conv_data_o, 64'h0000_0000_0040_0100);
		peak_hold_i = 4'h0;
		adc_fault_i = 1'b1;
		step(2);
		chk(alarm_status_word_o, 16'h4000);
		smp(64'h0000_0000_0001_0001);
		chk(conv_data_o, 64'h0000_0000_0040_0100);
		chk(unit_error_indicator_o, 1'b1);
		adc_fault_i = 1'b0;
		step(4);
		smp(64'h0000_0000_0022_0011);
		refresh_en = 1'b0;
		step(2 * TMO + 10);
		chk(host_monitor_err_o, 1'b1);
		chk(host_error_indicator_o, 1'b1);
		smp(64'h0000_0000_0777_0777);
		chk(conv_data_o, 64'h0000_0000_0022_0011);
		refresh_en = 1'b1;
		step(16);
		chk(host_monitor_err_o, 1'b0);
		conv_mode_i = 8'h01;
		step(4);
		chk(alarm_status_word_o, 16'h0000);
		restart(64'h0000_0000_0022_0011);
		chk(alarm_status_word_o, 16'h1000);
		chk(run_indicator_o, 1'b0);
		conv_mode_i = 8'hA5;
		restart(64'h0);
		chk(alarm_status_word_o, 16'h0000);
		smp(64'h0000_0000_0444_0444);
		chk(conv_data_o, 64'h0);
		cmd_req = 1'b1;
		step(4);
		disconnect_i = 4'h1;
		smp(64'h0000_0000_0444_0444);
		chk(conv_data_o, 64'h0000_0000_0444_7FFF);
		chk(alarm_status_word_o, 16'h0001);
		{cmd_req, disconnect_i} = 5'h00;
		step(2);
		chk(alarm_status_word_o, 16'h0000);
		for (i = 0; i < 6; i++) begin
			good();
			case (i)
				0: scale_hi_i[1] = 16'h8000;
				1: {scale_lo_i[0], scale_hi_i[0]} = {2{16'h0005}};
				2: used_count_i = 4'h5;
				3: range_code_i[3] = 4'h1;
				4: avg_count_i[1] = 4'hA;
				default: conv_mode_i = 8'h01;
			endcase
			rst();
			chk(alarm_status_word_o, 16'h0001 << err_bit[i]);
			chk(unit_error_indicator_o, 1'b1);
			chk(run_indicator_o, 1'b0);
			smp(64'h0000_0000_0555_0555);
			chk(conv_data_o, 64'h0);
		end
		good();
		rst();
		smp(64'h0000_0000_0666_0666);
		io_bus_err_i = 1'b1;
		step(6);
		chk(host_error_indicator_o, 1'b1);
		chk(run_indicator_o, 1'b1);
		chk(conv_data_o, 64'h0);
		io_bus_err_i = 1'b0;
		host_watchdog_err_i = 1'b1;
		step(6);
		chk(host_error_indicator_o, 1'b1);
		chk(run_indicator_o, 1'b1);
		host_watchdog_err_i = 1'b0;
		for (i = 0; i < 2; i++) begin
			step(6);
			smp(64'h0000_0000_0777_0777);
			{unit_dup_i, table_mismatch_i} = (i == 0) ? 2'h2 : 2'h1;
			step(6);
			chk(host_error_indicator_o, 1'b1);
			chk(run_indicator_o, 1'b0);
			smp(64'h0000_0000_0888_0888);
			chk(conv_data_o, 64'h0);
			{unit_dup_i, table_mismatch_i} = 2'h0;
		end
		unit_number_i = 8'h60;
		rst();
		chk(host_error_indicator_o, 1'b1);
		chk(run_indicator_o, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
